// ### src/omc_mode_ctrl.sv
// operating mode controller: command gating, modes, activity levels, events
// assumes commands and radio status are synchronous to i_clk; events always taken
`timescale 1ns/100ps
`default_nettype none
module omc_mode_ctrl import omc_pkg::*; #(
  parameter int P_VOL_WR_CYC = WR_VOL_CYC,
  parameter int P_NVM_WR_CYC = WR_NVM_CYC,
  parameter int P_MS_CYC = CYC_PER_MS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic [CMD_W-1:0] i_cmd_code,
  input wire logic [ARG_W-1:0] i_cmd_arg,
  input wire logic [UUID_BITS-1:0] i_cmd_data,
  input wire logic i_nvm_cfg_present,
  input wire logic i_link_up,
  input wire logic i_link_lost,
  input wire logic i_pipes_update,
  input wire logic [PIPE_W-1:0] i_pipes_open,
  input wire logic [UUID_SEL_W-1:0] i_uuid_sel,
  input wire logic [SHORT_BITS-1:0] i_uuid_short,
  output logic [UUID_BITS-1:0] o_uuid_full,
  output logic o_evt_valid,
  output logic [3:0] o_evt_code,
  output logic [3:0] o_evt_status,
  output logic [PIPE_W-1:0] o_evt_pipes,
  output logic [2:0] o_mode,
  output logic [1:0] o_activity,
  output logic o_dyn_clear,
  output logic o_radio_drop,
  output logic o_cfg_locked,
  output logic [1:0] o_test_feature,
  output logic o_data_accept
);
  omc_mode_type mode_reg;
  omc_act_type act_reg;
  omc_mode_type mode_next;
  omc_act_type act_next;
  omc_stat_type stat_next;
  omc_tfeat_type feat_reg;
  logic respond, start_wr, start_adv, do_clr, do_drop, do_base, do_data;
  logic cfg_vol_reg, locked_reg, wr_busy_reg, wr_nvm_reg;
  logic pend_up_reg, pend_chan_reg, pend_down_reg, pend_advto_reg, pend_any;
  logic [PIPE_W-1:0] pipes_reg;
  logic [TMR_W-1:0] ms_cnt_reg;
  logic ms_tick, take, link_evt;
  logic [UUID_BITS-1:0] base_mem [UUID_BASES];
  logic evt_valid_reg, dyn_clear_reg, drop_reg, data_reg;
  logic [3:0] evt_code_reg, evt_stat_reg;
  logic [PIPE_W-1:0] evt_pipes_reg;
  logic [UUID_BITS-1:0] uuid_reg;

  omc_tmr_if wr_t ();
  omc_tmr_if adv_t ();
  omc_timer u_wr_timer (.i_clk(i_clk), .i_rst(i_rst), .t(wr_t.tmr));
  omc_timer u_adv_timer (.i_clk(i_clk), .i_rst(i_rst), .t(adv_t.tmr));

  // writes run to completion before the answer: both fit the answer bound
  assign wr_t.load = take && start_wr;
  assign wr_t.value = i_cmd_arg[0] ? 32'(P_NVM_WR_CYC) : 32'(P_VOL_WR_CYC);
  assign wr_t.tick = 1'b1;
  assign wr_t.stop = 1'b0;
  assign adv_t.load = take && start_adv;
  assign adv_t.value = {16'h0, i_cmd_data[ADV_TO_W-1:0]};
  assign adv_t.tick = ms_tick;
  // leaving advertising stops the timer, so a live link outlives it
  // a load in the standby cycle must not be swallowed by the stop
  assign adv_t.stop = (act_reg != ACT_ADVERT) && !adv_t.load;

  assign ms_tick = (ms_cnt_reg == 32'(P_MS_CYC - 1));
  always_ff @(posedge i_clk) begin
    if (i_rst || adv_t.load || ms_tick) begin
      ms_cnt_reg <= '0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 1'b1;
    end
  end

  // a command waits while any radio event is in flight, so no event is lost
  assign pend_any = pend_up_reg | pend_chan_reg | pend_down_reg | pend_advto_reg;
  assign link_evt = i_link_up | i_link_lost | adv_t.expired;
  assign o_cmd_ready = (mode_reg != MODE_BOOT) && !wr_busy_reg && !pend_any && !link_evt;
  assign take = i_cmd_valid && o_cmd_ready;

  always_comb begin
    mode_next = mode_reg;
    act_next = act_reg;
    stat_next = ST_OK;
    respond = 1'b1;
    start_wr = 1'b0;
    start_adv = 1'b0;
    do_clr = 1'b0;
    do_drop = 1'b0;
    do_base = 1'b0;
    do_data = 1'b0;
    case (omc_cmd_type'(i_cmd_code))
      CMD_SLEEP: begin
        if (mode_reg == MODE_ACTIVE) begin
          mode_next = MODE_SLEEP;
          act_next = ACT_STANDBY;
          do_drop = (act_reg != ACT_STANDBY);
        end else begin
          stat_next = ST_ERR_STATE;
        end
      end
      CMD_WAKEUP: begin
        if (mode_reg == MODE_SLEEP) begin
          mode_next = MODE_ACTIVE;
          act_next = ACT_STANDBY;
        end else begin
          stat_next = ST_ERR_STATE;
        end
      end
      CMD_SETUP: begin
        if (mode_reg == MODE_ACTIVE || mode_reg == MODE_TEST) begin
          mode_next = MODE_SETUP;
          act_next = ACT_STANDBY;
          do_clr = 1'b1;
          do_drop = (act_reg != ACT_STANDBY);
        end else begin
          stat_next = ST_ERR_STATE;
        end
      end
      CMD_TEST: begin
        if (mode_reg != MODE_ACTIVE && mode_reg != MODE_SETUP) begin
          stat_next = ST_ERR_STATE;
        end else if (i_cmd_arg[1:0] != TFEAT_PHY_DIRECT && i_cmd_arg[1:0] != TFEAT_HOST_LINK) begin
          stat_next = ST_ERR_PARAM;
        end else begin
          mode_next = MODE_TEST;
          act_next = ACT_STANDBY;
          do_clr = 1'b1;
          do_drop = (act_reg != ACT_STANDBY);
        end
      end
      CMD_SETUP_WR: begin
        if (mode_reg != MODE_SETUP) begin
          stat_next = ST_ERR_STATE;
        end else if (locked_reg) begin
          stat_next = ST_ERR_LOCKED;
        end else begin
          start_wr = 1'b1;
          respond = 1'b0;
        end
      end
      CMD_SETUP_END: begin
        if (mode_reg != MODE_SETUP) begin
          stat_next = ST_ERR_STATE;
        end else if (!cfg_vol_reg && !locked_reg) begin
          stat_next = ST_ERR_NO_SETUP;
        end else begin
          mode_next = MODE_ACTIVE;
          act_next = ACT_STANDBY;
        end
      end
      CMD_BASE_WR: begin
        if (mode_reg != MODE_SETUP) begin
          stat_next = ST_ERR_STATE;
        end else if (locked_reg) begin
          stat_next = ST_ERR_LOCKED;
        end else if (i_cmd_arg >= 3'(UUID_BASES)) begin
          stat_next = ST_ERR_PARAM;
        end else begin
          do_base = 1'b1;
        end
      end
      CMD_CONNECT, CMD_BOND: begin
        if (mode_reg != MODE_ACTIVE || act_reg != ACT_STANDBY) begin
          stat_next = ST_ERR_STATE;
        end else if (i_cmd_data[ADV_TO_W-1:0] == 16'h0) begin
          stat_next = ST_ERR_PARAM;
        end else begin
          act_next = ACT_ADVERT;
          start_adv = 1'b1;
        end
      end
      CMD_DISCONNECT: begin
        if (mode_reg == MODE_ACTIVE && act_reg != ACT_STANDBY) begin
          act_next = ACT_STANDBY;
          do_drop = 1'b1;
        end else begin
          stat_next = ST_ERR_STATE;
        end
      end
      CMD_DATA: begin
        if (mode_reg != MODE_ACTIVE) begin
          stat_next = ST_ERR_NO_SETUP;
        end else if (act_reg != ACT_CONN || pipes_reg == PIPES_RST) begin
          stat_next = ST_ERR_STATE;
        end else begin
          do_data = 1'b1;
        end
      end
      default: begin
        stat_next = ST_ERR_CMD;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_reg <= MODE_BOOT;
    end else if (mode_reg == MODE_BOOT) begin
      mode_reg <= i_nvm_cfg_present ? MODE_ACTIVE : MODE_SETUP;
    end else if (take) begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      act_reg <= ACT_STANDBY;
    end else if (take) begin
      act_reg <= act_next;
    end else begin
      unique case (act_reg)
        ACT_STANDBY: act_reg <= ACT_STANDBY;
        ACT_ADVERT: begin
          if (i_link_up) begin
            act_reg <= ACT_CONN;
          end else if (adv_t.expired) begin
            act_reg <= ACT_STANDBY;
          end
        end
        ACT_CONN: begin
          if (i_link_lost) begin
            act_reg <= ACT_STANDBY;
          end
        end
        default: act_reg <= ACT_STANDBY;
      endcase
    end
  end

  // configuration store: volatile copy never survives reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_vol_reg <= 1'b0;
      locked_reg <= 1'b0;
      wr_busy_reg <= 1'b0;
      wr_nvm_reg <= 1'b0;
    end else begin
      if (mode_reg == MODE_BOOT) begin
        locked_reg <= i_nvm_cfg_present;
      end
      if (take && start_wr) begin
        wr_busy_reg <= 1'b1;
        wr_nvm_reg <= i_cmd_arg[0];
      end else if (wr_t.expired) begin
        wr_busy_reg <= 1'b0;
        cfg_vol_reg <= 1'b1;
        if (wr_nvm_reg) begin
          locked_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      feat_reg <= TFEAT_NONE;
    end else if (take && mode_next == MODE_TEST && mode_reg != MODE_TEST) begin
      feat_reg <= omc_tfeat_type'(i_cmd_arg[1:0]);
    end else if (mode_reg != MODE_TEST) begin
      feat_reg <= TFEAT_NONE;
    end
  end

  // notices raised by the radio side; a set in the drain cycle wins
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend_up_reg <= 1'b0;
      pend_chan_reg <= 1'b0;
      pend_down_reg <= 1'b0;
      pend_advto_reg <= 1'b0;
      pipes_reg <= PIPES_RST;
    end else begin
      if (act_reg == ACT_ADVERT && i_link_up) begin
        pend_up_reg <= 1'b1;
        pend_chan_reg <= 1'b1;
        pipes_reg <= i_pipes_open;
      end else begin
        pend_up_reg <= 1'b0;
        if (act_reg == ACT_CONN && i_pipes_update && !i_link_lost) begin
          pend_chan_reg <= 1'b1;
          pipes_reg <= i_pipes_open;
        end else if (!pend_up_reg) begin
          pend_chan_reg <= 1'b0;
        end
      end
      if (act_reg == ACT_CONN && i_link_lost) begin
        pend_down_reg <= 1'b1;
        pipes_reg <= PIPES_RST;
      end else if (!pend_up_reg && !pend_chan_reg) begin
        pend_down_reg <= 1'b0;
      end
      if (act_reg == ACT_ADVERT && adv_t.expired && !i_link_up) begin
        pend_advto_reg <= 1'b1;
      end else if (!pend_up_reg && !pend_chan_reg && !pend_down_reg) begin
        pend_advto_reg <= 1'b0;
      end
      if (take && do_drop) begin
        pipes_reg <= PIPES_RST;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_valid_reg <= 1'b0;
      evt_code_reg <= EVT_NONE;
      evt_stat_reg <= ST_OK;
      evt_pipes_reg <= PIPES_RST;
    end else begin
      evt_valid_reg <= 1'b1;
      evt_stat_reg <= ST_OK;
      evt_pipes_reg <= pipes_reg;
      if (mode_reg == MODE_BOOT) begin
        evt_code_reg <= EVT_STARTUP_DONE;
      end else if (wr_t.expired || (take && respond)) begin
        evt_code_reg <= EVT_RESPONSE;
        evt_stat_reg <= take ? stat_next : ST_OK;
      end else if (pend_up_reg) begin
        evt_code_reg <= EVT_LINK_UP;
      end else if (pend_chan_reg) begin
        evt_code_reg <= EVT_CHAN_AVAIL;
      end else if (pend_down_reg) begin
        evt_code_reg <= EVT_LINK_DOWN;
      end else if (pend_advto_reg) begin
        evt_code_reg <= EVT_ADV_TIMEOUT;
      end else begin
        evt_valid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dyn_clear_reg <= 1'b0;
      drop_reg <= 1'b0;
      data_reg <= 1'b0;
    end else begin
      dyn_clear_reg <= (mode_reg == MODE_BOOT) || (take && do_clr);
      drop_reg <= take && do_drop;
      data_reg <= take && do_data;
    end
  end

  // base identifiers are volatile here; a locked store refuses base writes, so after a stored boot they stay at UUID_RST
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < UUID_BASES; i++) begin
        base_mem[i] <= UUID_RST;
      end
    end else if (take && do_base) begin
      base_mem[i_cmd_arg] <= i_cmd_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      uuid_reg <= UUID_RST;
    end else if (i_uuid_sel < 3'(UUID_BASES)) begin
      uuid_reg <= base_mem[i_uuid_sel];
      uuid_reg[SHORT_LSB +: SHORT_BITS] <= i_uuid_short;
    end else begin
      uuid_reg <= UUID_RST;
    end
  end

  assign o_uuid_full = uuid_reg;
  assign o_evt_valid = evt_valid_reg;
  assign o_evt_code = evt_code_reg;
  assign o_evt_status = evt_stat_reg;
  assign o_evt_pipes = evt_pipes_reg;
  assign o_mode = mode_reg;
  assign o_activity = act_reg;
  assign o_dyn_clear = dyn_clear_reg;
  assign o_radio_drop = drop_reg;
  assign o_cfg_locked = locked_reg;
  assign o_test_feature = feat_reg;
  assign o_data_accept = data_reg;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_startup_notice: assert property (!i_rst && mode_reg == MODE_BOOT |=> o_evt_valid && o_evt_code == EVT_STARTUP_DONE) else $error("startup notice missing");
  a_boot_target: assert property (!i_rst && mode_reg == MODE_BOOT |=> mode_reg == (i_nvm_cfg_present ? MODE_ACTIVE : MODE_SETUP) && o_dyn_clear) else $error("wrong mode after reset");
  a_setup_clear: assert property ($changed(mode_reg) && (mode_reg == MODE_SETUP || mode_reg == MODE_TEST) && $past(mode_reg) != MODE_BOOT |-> o_dyn_clear) else $error("dynamic data not cleared");
  a_wake_standby: assert property ($past(mode_reg) == MODE_SLEEP && mode_reg == MODE_ACTIVE |-> act_reg == ACT_STANDBY) else $error("wakeup not to standby");
  a_sleep_drop: assert property (take && i_cmd_code == CMD_SLEEP && mode_reg == MODE_ACTIVE && act_reg == ACT_CONN |=> o_radio_drop && mode_reg == MODE_SLEEP) else $error("sleep kept link");
  a_bad_keep: assert property (take && stat_next != ST_OK |=> $stable(mode_reg) && o_evt_code == EVT_RESPONSE && o_evt_status != ST_OK) else $error("bad command changed mode");
  a_locked_refuse: assert property (take && i_cmd_code == CMD_SETUP_WR && mode_reg == MODE_SETUP && locked_reg |=> o_evt_status == ST_ERR_LOCKED && !wr_busy_reg) else $error("locked store rewritten");
  a_data_gate: assert property (take && i_cmd_code == CMD_DATA && mode_reg != MODE_ACTIVE |=> !o_data_accept && o_evt_status == ST_ERR_NO_SETUP) else $error("data before setup");
  a_adv_start: assert property (take && start_adv |=> act_reg == ACT_ADVERT ##1 act_reg != ACT_STANDBY || $past(take) || $past(adv_t.expired)) else $error("advertising not started");
  a_adv_fallback: assert property (act_reg == ACT_ADVERT && adv_t.expired && !i_link_up |=> act_reg == ACT_STANDBY ##1 o_evt_code == EVT_ADV_TIMEOUT) else $error("timeout not to standby");
  a_link_notices: assert property (act_reg == ACT_ADVERT && i_link_up |=> act_reg == ACT_CONN ##1 o_evt_code == EVT_LINK_UP ##1 o_evt_code == EVT_CHAN_AVAIL) else $error("link notices out of order");
  a_uuid_short: assert property (!i_rst && i_uuid_sel < 3'(UUID_BASES) |=> o_uuid_full[SHORT_LSB +: SHORT_BITS] == $past(i_uuid_short)) else $error("short identifier misplaced");
endmodule : omc_mode_ctrl
`default_nettype wire

// ### src/omc_pkg.sv
// operating mode controller: shared constants, codes and state types
// assumes a single 100 MHz clock; all timing counts derive from CLK_MHZ
package omc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int WR_VOL_MS = 50;
  localparam int WR_NVM_MS = 1600;
  localparam int RESP_MAX_MS = 2000;
  localparam int WR_VOL_CYC = WR_VOL_MS * CYC_PER_MS;
  localparam int WR_NVM_CYC = WR_NVM_MS * CYC_PER_MS;
  localparam int RESP_MAX_CYC = RESP_MAX_MS * CYC_PER_MS;
  localparam int CFG_BYTES = 1616;

  localparam int TMR_W = 32;
  localparam int CMD_W = 4;
  localparam int ARG_W = 3;
  localparam int PIPE_W = 8;
  localparam int UUID_BITS = 128;
  localparam int UUID_BASES = 5;
  localparam int UUID_SEL_W = 3;
  localparam int SHORT_BITS = 16;
  localparam int SHORT_LSB = 96;
  localparam int ADV_TO_W = 16;

  localparam logic [PIPE_W-1:0] PIPES_RST = 8'h00;
  localparam logic [UUID_BITS-1:0] UUID_RST = 128'h0;

  typedef enum logic [2:0] {
    MODE_BOOT = 3'b000,
    MODE_SLEEP = 3'b001,
    MODE_SETUP = 3'b010,
    MODE_ACTIVE = 3'b011,
    MODE_TEST = 3'b100
  } omc_mode_type;

  typedef enum logic [1:0] {
    ACT_STANDBY = 2'b00,
    ACT_ADVERT = 2'b01,
    ACT_CONN = 2'b10
  } omc_act_type;

  typedef enum logic [CMD_W-1:0] {
    CMD_TEST = 4'h1,
    CMD_SLEEP = 4'h2,
    CMD_WAKEUP = 4'h3,
    CMD_SETUP = 4'h4,
    CMD_SETUP_WR = 4'h5,
    CMD_SETUP_END = 4'h6,
    CMD_BASE_WR = 4'h7,
    CMD_CONNECT = 4'h8,
    CMD_BOND = 4'h9,
    CMD_DISCONNECT = 4'hA,
    CMD_DATA = 4'hB
  } omc_cmd_type;

  typedef enum logic [3:0] {
    EVT_NONE = 4'h0,
    EVT_STARTUP_DONE = 4'h1,
    EVT_RESPONSE = 4'h2,
    EVT_LINK_UP = 4'h3,
    EVT_CHAN_AVAIL = 4'h4,
    EVT_LINK_DOWN = 4'h5,
    EVT_ADV_TIMEOUT = 4'h6
  } omc_evt_type;

  typedef enum logic [3:0] {
    ST_OK = 4'h0,
    ST_ERR_STATE = 4'h1,
    ST_ERR_LOCKED = 4'h2,
    ST_ERR_NO_SETUP = 4'h3,
    ST_ERR_PARAM = 4'h4,
    ST_ERR_CMD = 4'h5
  } omc_stat_type;

  typedef enum logic [1:0] {
    TFEAT_NONE = 2'b00,
    TFEAT_PHY_DIRECT = 2'b01,
    TFEAT_HOST_LINK = 2'b10
  } omc_tfeat_type;
endpackage : omc_pkg

// ### src/omc_tmr_if.sv
// control and status bundle between the mode controller and a countdown timer
// assumes both ends share i_clk
`timescale 1ns/100ps
`default_nettype none
interface omc_tmr_if import omc_pkg::*; ();
  logic load;
  logic stop;
  logic tick;
  logic [TMR_W-1:0] value;
  logic expired;
  modport ctl (output load, output stop, output tick, output value, input expired);
  modport tmr (input load, input stop, input tick, input value, output expired);
endinterface : omc_tmr_if
`default_nettype wire

// ### src/omc_timer.sv
// countdown timer: counts value ticks after load, then one expiry pulse
// assumes tick is a one-cycle enable from the owner's clock
`timescale 1ns/100ps
`default_nettype none
module omc_timer import omc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  omc_tmr_if.tmr t
);
  logic [TMR_W-1:0] count_reg;
  logic run_reg;
  logic exp_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst || t.stop) begin
      run_reg <= 1'b0;
      count_reg <= '0;
    end else if (t.load) begin
      count_reg <= t.value;
      run_reg <= (t.value != '0);
    end else if (run_reg && t.tick) begin
      count_reg <= count_reg - 1'b1;
      if (count_reg == 32'h1) begin
        run_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      exp_reg <= 1'b0;
    end else begin
      exp_reg <= run_reg && t.tick && !t.stop && !t.load && (count_reg == 32'h1);
    end
  end

  assign t.expired = exp_reg;
endmodule : omc_timer
`default_nettype wire

// ### tb/omc_host_model.sv
// host side model: issues one command at a time and waits for its answer
// assumes the bench calls send from a single process
`timescale 1ns/100ps
`default_nettype none
module omc_host_model import omc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_ready,
  input wire logic i_evt_valid,
  input wire logic [3:0] i_evt_code,
  input wire logic [3:0] i_evt_status,
  output logic o_cmd_valid,
  output logic [CMD_W-1:0] o_cmd_code,
  output logic [ARG_W-1:0] o_cmd_arg,
  output logic [UUID_BITS-1:0] o_cmd_data
);
  logic started_reg;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 4'h0;
    o_cmd_arg = 3'h0;
    o_cmd_data = 128'h0;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      started_reg <= 1'b0;
    end else if (i_evt_valid === 1'b1 && i_evt_code === 4'h1) begin
      started_reg <= 1'b1;
    end
  end
  // status F marks a command that was never taken or never answered
  task automatic send(input logic [3:0] c, input logic [2:0] a, input logic [127:0] d,
                      output logic [3:0] st);
    int n;
    n = 0;
    while (started_reg !== 1'b1) @(posedge i_clk);
    @(posedge i_clk);
    o_cmd_code <= c;
    o_cmd_arg <= a;
    o_cmd_data <= d;
    o_cmd_valid <= 1'b1;
    @(posedge i_clk);
    while (i_cmd_ready !== 1'b1 && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    // released lines show inverted stale values, never the last command
    o_cmd_valid <= 1'b0;
    o_cmd_code <= ~c;
    o_cmd_arg <= ~a;
    o_cmd_data <= ~d;
    while (!(i_evt_valid === 1'b1 && i_evt_code === 4'h2) && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    st = (n < 400) ? i_evt_status : 4'hF;
  endtask : send
endmodule : omc_host_model
`default_nettype wire

// ### tb/tb_top.sv
// bench for the operating mode controller: command table, then radio and reset cases
// assumes the host model owns the command port; radio inputs are driven here
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [3:0] code;
    logic [2:0] arg;
    logic [15:0] d;
    logic [3:0] st;
    logic [2:0] mode;
    logic [1:0] act;
  } omc_tb_row_type;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic nvm = 1'b0;
  logic link_up = 1'b0;
  logic link_lost = 1'b0;
  logic [7:0] pipes = 8'h00;
  logic [2:0] usel = 3'h2;
  logic [15:0] ushort = 16'hABCD;
  logic cv, rdy, ev, dclr, lock;
  logic [3:0] cc, ec, es, st;
  logic [2:0] ca, mode;
  logic [127:0] cd, ufull;
  logic [7:0] ep;
  logic [1:0] act, tfeat;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_dyn = 0;
  int n_drop = 0;
  int n_acc = 0;
  logic pupd = 1'b0;
  logic rdrop, dacc;
  logic [1:0] efeat = 2'h0;
  int i;
  omc_tb_row_type rows [26];
  omc_mode_ctrl #(.P_VOL_WR_CYC(20), .P_NVM_WR_CYC(60), .P_MS_CYC(4)) omc_mode_ctrl_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(cv), .o_cmd_ready(rdy), .i_cmd_code(cc),
    .i_cmd_arg(ca), .i_cmd_data(cd), .i_nvm_cfg_present(nvm), .i_link_up(link_up),
    .i_link_lost(link_lost), .i_pipes_update(pupd), .i_pipes_open(pipes), .i_uuid_sel(usel),
    .i_uuid_short(ushort), .o_uuid_full(ufull), .o_evt_valid(ev), .o_evt_code(ec),
    .o_evt_status(es), .o_evt_pipes(ep), .o_mode(mode), .o_activity(act),
    .o_dyn_clear(dclr), .o_radio_drop(rdrop), .o_cfg_locked(lock), .o_test_feature(tfeat),
    .o_data_accept(dacc));
  omc_host_model omc_host_model_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_cmd_ready(rdy), .i_evt_valid(ev), .i_evt_code(ec),
    .i_evt_status(es), .o_cmd_valid(cv), .o_cmd_code(cc), .o_cmd_arg(ca), .o_cmd_data(cd));
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (dclr === 1'b1) n_dyn++;
    if (rdrop === 1'b1) n_drop++;
    if (dacc === 1'b1) n_acc++;
    // the whole run needs well under a thousand cycles
    if (cyc == 6000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic boot(input logic nv);
    int n;
    n = 0;
    i_rst <= 1'b1;
    nvm <= nv;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (ev !== 1'b1 && n < 20);
    chk(128'(ec), 128'h1, "startup");
    chk(128'(mode), nv ? 128'h3 : 128'h2, "boot mode");
    chk(128'(dclr), 128'h1, "boot clear");
    chk(128'(lock), 128'(nv), "boot lock");
  endtask : boot
  initial begin
    rows = '{'{4'hB, 3'h0, 16'h0, 4'h3, 3'h2, 2'h0},
             '{4'h6, 3'h0, 16'h0, 4'h3, 3'h2, 2'h0},
             '{4'h7, 3'h2, 16'h5A5A, 4'h0, 3'h2, 2'h0},
             '{4'h7, 3'h5, 16'h5A5A, 4'h4, 3'h2, 2'h0},
             '{4'h5, 3'h0, 16'h0, 4'h0, 3'h2, 2'h0},
             '{4'h6, 3'h0, 16'h0, 4'h0, 3'h3, 2'h0},
             '{4'h3, 3'h0, 16'h0, 4'h1, 3'h3, 2'h0},
             '{4'h8, 3'h0, 16'h0, 4'h4, 3'h3, 2'h0},
             '{4'h8, 3'h0, 16'h3, 4'h0, 3'h3, 2'h1},
             '{4'hA, 3'h0, 16'h0, 4'h0, 3'h3, 2'h0},
             '{4'h8, 3'h0, 16'h3, 4'h0, 3'h3, 2'h1},
             '{4'h2, 3'h0, 16'h0, 4'h0, 3'h1, 2'h0},
             '{4'h3, 3'h0, 16'h0, 4'h0, 3'h3, 2'h0},
             '{4'h1, 3'h1, 16'h0, 4'h0, 3'h4, 2'h0},
             '{4'h2, 3'h0, 16'h0, 4'h1, 3'h4, 2'h0},
             '{4'h4, 3'h0, 16'h0, 4'h0, 3'h2, 2'h0},
             '{4'h1, 3'h2, 16'h0, 4'h0, 3'h4, 2'h0},
             '{4'h4, 3'h0, 16'h0, 4'h0, 3'h2, 2'h0},
             '{4'hF, 3'h0, 16'h0, 4'h5, 3'h2, 2'h0},
             '{4'h5, 3'h1, 16'h0, 4'h0, 3'h2, 2'h0},
             '{4'h5, 3'h0, 16'h0, 4'h2, 3'h2, 2'h0},
             '{4'h6, 3'h0, 16'h0, 4'h0, 3'h3, 2'h0},
             '{4'h4, 3'h0, 16'h0, 4'h0, 3'h2, 2'h0},
             '{4'h7, 3'h1, 16'h5A5A, 4'h2, 3'h2, 2'h0},
             '{4'h6, 3'h0, 16'h0, 4'h0, 3'h3, 2'h0},
             '{4'hB, 3'h0, 16'h0, 4'h1, 3'h3, 2'h0}};
    boot(1'b0);
    n_dyn = 0;
    for (i = 0; i < 26; i++) begin
      omc_host_model_i.send(rows[i].code, rows[i].arg, {8{rows[i].d}}, st);
      #1;
      chk(128'(st), 128'(rows[i].st), "status");
      chk(128'(mode), 128'(rows[i].mode), "mode");
      chk(128'(act), 128'(rows[i].act), "activity");
      if (rows[i].code == 4'h1 && rows[i].st == 4'h0) efeat = rows[i].arg[1:0];
      if (rows[i].mode == 3'h4) chk(128'(tfeat), 128'(efeat), "feature");
      if (i == 3) chk(ufull, {16'h5A5A, ushort, {6{16'h5A5A}}}, "uuid");
    end
    // boot clear plus five entries into setup or test
    chk(128'(n_dyn), 128'h6, "clears");
    chk(128'(n_drop), 128'h2, "drops");
    chk(128'(lock), 128'h1, "locked");
    @(posedge i_clk);
    usel <= 3'h5;
    repeat (2) @(posedge i_clk);
    #1;
    chk(ufull, 128'h0, "uuid range");
    $display("test table done");
    omc_host_model_i.send(4'h8, 3'h0, 128'h3, st);
    link_up <= 1'b1;
    pipes <= 8'h05;
    @(posedge i_clk);
    link_up <= 1'b0;
    #1;
    chk(128'(act), 128'h2, "connected");
    @(posedge i_clk);
    #1;
    chk(128'({ev, ec}), 128'h13, "link notice");
    @(posedge i_clk);
    #1;
    chk(128'({ev, ec, ep}), 128'h1405, "chan notice");
    repeat (20) @(posedge i_clk);
    #1;
    chk(128'(act), 128'h2, "kept link");
    @(posedge i_clk);
    pupd <= 1'b1;
    pipes <= 8'h03;
    @(posedge i_clk);
    pupd <= 1'b0;
    @(posedge i_clk);
    #1;
    chk(128'({ev, ec, ep}), 128'h1403, "chan update");
    omc_host_model_i.send(4'hB, 3'h0, 128'h0, st);
    chk(128'(st), 128'h0, "data");
    @(posedge i_clk);
    link_lost <= 1'b1;
    @(posedge i_clk);
    link_lost <= 1'b0;
    #1;
    chk(128'(act), 128'h0, "link lost");
    @(posedge i_clk);
    #1;
    chk(128'({ev, ec}), 128'h15, "down notice");
    chk(128'(n_acc), 128'h1, "data passed");
    $display("test link done");
    omc_host_model_i.send(4'h9, 3'h0, 128'h2, st);
    chk(128'({st, act}), 128'h1, "bond");
    i = 0;
    do begin
      @(posedge i_clk);
      #1;
      i++;
    end while (!(ev === 1'b1 && ec === 4'h6) && i < 40);
    chk(128'({ec, act}), 128'h18, "adv timeout");
    $display("test timeout done");
    @(posedge i_clk);
    boot(1'b1);
    $display("test stored boot done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
